/* File: hw/cqdm_map.svh */
`ifndef CQDM_MAP_SVH
`define CQDM_MAP_SVH

`define CQDM_OFS_OVF_MASK  8'h64
`define CQDM_OFS_OVF_VEC   8'h68
`define CQDM_OFS_CONFIG    8'h74
`define CQDM_OFS_LIMIT0    8'h78
`define CQDM_OFS_LIMIT3    8'h84
`define CQDM_OFS_AVAIL0    8'h88
`define CQDM_OFS_AVAIL3    8'h94
`define CQDM_OFS_WEIGHT0   8'h98
`define CQDM_OFS_WEIGHT1   8'h9c
`define CQDM_OFS_DUR_VEC   8'ha0
`define CQDM_OFS_WMARK0    8'ha4
`define CQDM_OFS_WMARK1    8'ha8

`define CQDM_CFG_Q_EN      0
`define CQDM_CFG_Q_SRST    1
`define CQDM_CFG_Q_RELOAD  2
`define CQDM_CFG_D_EN      6
`define CQDM_CFG_D_SRST    7

`define CQDM_CORES         4
`define CQDM_EV_PER_CORE   2
`define CQDM_EVENTS        8
`define CQDM_COUNTERS      24
`define CQDM_WBITS         8
`define CQDM_CNT_MAX       8'hff
`define CQDM_RESET_WORD    32'h0000_0000

`endif

/* File: hw/cqdm_pkg.sv */
package cqdm_pkg;

	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} cqdm_apb_req_s;

	typedef struct packed {
		logic       durSoftReset;
		logic       durEnable;
		logic [3:0] quotaReload;
		logic       quotaSoftReset;
		logic       quotaEnable;
	} cqdm_cfg_s;

	typedef logic [7:0] cqdm_weight_t;

endpackage

/* File: hw/cqdm_top.sv */
`timescale 1ns/10ps
`include "cqdm_map.svh"

module cqdm_top
(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// register port
	input  wire cqdm_pkg::cqdm_apb_req_s apbReq,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	// events from crossbar outputs 0..7 and base counter wraps
	input  wire logic [7:0]             eventIn,
	input  wire logic [23:0]            counterWrap,
	input  wire logic                   overflowSoftReset,
	// interrupt lines
	output logic [3:0]                  irqQuota,
	output logic                        irqDuration,
	output logic                        irqOverflow
);

////////////////////////////////////////////////////////////////////////////////
// helpers

function automatic logic [7:0] satInc(input logic [7:0] v);
	satInc = (v == `CQDM_CNT_MAX) ? v : v + 8'h01;
endfunction

function automatic logic [31:0] pack4(input logic [31:0] v);
	pack4 = v;
endfunction

function automatic logic [31:0] coreContention(
	input logic [7:0]  ev,
	input logic [63:0] w,
	input int          core);
	logic [31:0] s;
	s = 32'h0000_0000;
	for (int e = 0; e < `CQDM_EV_PER_CORE; e++)
	begin
		if (ev[core*`CQDM_EV_PER_CORE+e])
			s = s + {24'h000000, w[(core*`CQDM_EV_PER_CORE+e)*8 +: 8]};
	end
	coreContention = s;
endfunction

////////////////////////////////////////////////////////////////////////////////
// register port

cqdm_pkg::cqdm_cfg_s cfgReg, cfgNext;
logic [31:0] limitReg [4];
logic [31:0] limitNext [4];
logic [63:0] weightReg, weightNext;
logic [23:0] ovfMaskReg, ovfMaskNext;
logic [31:0] rdataReg, rdataNext;
logic [31:0] availReg [4];
logic [31:0] availNext [4];
logic [3:0]  quotaIrqReg, quotaIrqNext;
logic [7:0]  durCntReg [8];
logic [7:0]  durCntNext [8];
logic [63:0] wmarkReg, wmarkNext;
logic [7:0]  durVecReg, durVecNext;
logic [23:0] ovfVecReg, ovfVecNext;

logic        wrEn;
logic        mapped;
logic [31:0] rdMux;
logic [7:0]  a;

assign a      = apbReq.paddr;
assign wrEn   = apbReq.psel & apbReq.penable & apbReq.pwrite;
assign pready = 1'b1;
assign prdata = rdataReg;

always_comb
begin
	mapped = 1'b1;
	rdMux  = `CQDM_RESET_WORD;
	case (a)
		`CQDM_OFS_OVF_MASK: rdMux = {8'h00, ovfMaskReg};
		`CQDM_OFS_OVF_VEC:  rdMux = {8'h00, ovfVecReg};
		`CQDM_OFS_CONFIG:   rdMux = {24'h000000, cfgReg};
		`CQDM_OFS_WEIGHT0:  rdMux = weightReg[31:0];
		`CQDM_OFS_WEIGHT1:  rdMux = weightReg[63:32];
		`CQDM_OFS_DUR_VEC:  rdMux = {24'h000000, durVecReg};
		`CQDM_OFS_WMARK0:   rdMux = wmarkReg[31:0];
		`CQDM_OFS_WMARK1:   rdMux = wmarkReg[63:32];
		default:
		begin
			if (a >= `CQDM_OFS_LIMIT0 && a <= `CQDM_OFS_LIMIT3 && a[1:0] == 2'b00)
				rdMux = limitReg[2'(a[3:2] + 2'h2)];
			else if (a >= `CQDM_OFS_AVAIL0 && a <= `CQDM_OFS_AVAIL3 && a[1:0] == 2'b00)
				rdMux = pack4(availReg[2'(a[3:2] + 2'h2)]);
			else
				mapped = 1'b0;
		end
	endcase
end

assign pslverr = apbReq.psel & apbReq.penable & ~mapped;

always_comb
begin
	cfgNext     = cfgReg;
	weightNext  = weightReg;
	ovfMaskNext = ovfMaskReg;
	rdataNext   = rdataReg;
	for (int c = 0; c < `CQDM_CORES; c++)
		limitNext[c] = limitReg[c];
	if (apbReq.psel & ~apbReq.penable & ~apbReq.pwrite)
		rdataNext = rdMux;
	if (wrEn)
	begin
		case (a)
			`CQDM_OFS_OVF_MASK: ovfMaskNext = apbReq.pwdata[23:0];
			`CQDM_OFS_CONFIG:   cfgNext = apbReq.pwdata[7:0];
			`CQDM_OFS_WEIGHT0:  weightNext[31:0] = apbReq.pwdata;
			`CQDM_OFS_WEIGHT1:  weightNext[63:32] = apbReq.pwdata;
			default:
			begin
				if (a >= `CQDM_OFS_LIMIT0 && a <= `CQDM_OFS_LIMIT3 && a[1:0] == 2'b00)
					limitNext[2'(a[3:2] + 2'h2)] = apbReq.pwdata;
			end
		endcase
	end
end

always_ff @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		cfgReg     <= '0;
		weightReg  <= 64'h0;
		ovfMaskReg <= 24'h000000;
		rdataReg   <= `CQDM_RESET_WORD;
		for (int c = 0; c < `CQDM_CORES; c++)
			limitReg[c] <= `CQDM_RESET_WORD;
	end
	else
	begin
		cfgReg     <= cfgNext;
		weightReg  <= weightNext;
		ovfMaskReg <= ovfMaskNext;
		rdataReg   <= rdataNext;
		for (int c = 0; c < `CQDM_CORES; c++)
			limitReg[c] <= limitNext[c];
	end
end

////////////////////////////////////////////////////////////////////////////////
// contention quota unit

logic [31:0] cont [4];

always_comb
begin
	for (int c = 0; c < `CQDM_CORES; c++)
	begin
		cont[c]         = coreContention(eventIn, weightReg, c);
		availNext[c]    = availReg[c];
		quotaIrqNext[c] = quotaIrqReg[c];
		if (cfgReg.quotaReload[c])
		begin
			availNext[c]    = limitReg[c];
			quotaIrqNext[c] = 1'b0;
		end
		else if (cfgReg.quotaSoftReset)
		begin
			availNext[c]    = `CQDM_RESET_WORD;
			quotaIrqNext[c] = 1'b0;
		end
		else if (cfgReg.quotaEnable)
		begin
			if (availReg[c] < cont[c])
			begin
				availNext[c]    = `CQDM_RESET_WORD;
				quotaIrqNext[c] = 1'b1;
			end
			else
				availNext[c] = availReg[c] - cont[c];
		end
	end
end

always_ff @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		quotaIrqReg <= 4'h0;
		for (int c = 0; c < `CQDM_CORES; c++)
			availReg[c] <= `CQDM_RESET_WORD;
	end
	else
	begin
		quotaIrqReg <= quotaIrqNext;
		for (int c = 0; c < `CQDM_CORES; c++)
			availReg[c] <= availNext[c];
	end
end

assign irqQuota = quotaIrqReg;

////////////////////////////////////////////////////////////////////////////////
// pulse duration monitor

always_comb
begin
	wmarkNext  = wmarkReg;
	durVecNext = durVecReg;
	for (int e = 0; e < `CQDM_EVENTS; e++)
	begin
		durCntNext[e] = durCntReg[e];
		if (cfgReg.durSoftReset)
		begin
			durCntNext[e]        = 8'h00;
			wmarkNext[e*8 +: 8]  = 8'h00;
			durVecNext[e]        = 1'b0;
		end
		else if (cfgReg.durEnable)
		begin
			durCntNext[e] = eventIn[e] ? satInc(durCntReg[e]) : 8'h00;
			if (durCntNext[e] > wmarkReg[e*8 +: 8])
				wmarkNext[e*8 +: 8] = durCntNext[e];
			if (wmarkNext[e*8 +: 8] > weightReg[e*8 +: 8])
				durVecNext[e] = 1'b1;
		end
	end
end

always_ff @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		wmarkReg  <= 64'h0;
		durVecReg <= 8'h00;
		for (int e = 0; e < `CQDM_EVENTS; e++)
			durCntReg[e] <= 8'h00;
	end
	else
	begin
		wmarkReg  <= wmarkNext;
		durVecReg <= durVecNext;
		for (int e = 0; e < `CQDM_EVENTS; e++)
			durCntReg[e] <= durCntNext[e];
	end
end

assign irqDuration = |durVecReg;

////////////////////////////////////////////////////////////////////////////////
// overflow detection

always_comb
begin
	ovfVecNext = ovfVecReg;
	if (overflowSoftReset)
		ovfVecNext = 24'h000000;
	ovfVecNext = ovfVecNext | (counterWrap & ovfMaskReg);
end

always_ff @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
		ovfVecReg <= 24'h000000;
	else
		ovfVecReg <= ovfVecNext;
end

assign irqOverflow = |ovfVecReg;

////////////////////////////////////////////////////////////////////////////////
// checks

default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);

chk_reload_copy: assert property (
	cfgReg.quotaReload[0] |=> availReg[0] == $past(limitReg[0]))
	else $error("reload did not copy limit");

chk_quota_dec: assert property (
	cfgReg.quotaEnable && !cfgReg.quotaReload[0] && !cfgReg.quotaSoftReset
	&& availReg[0] >= cont[0] |=> availReg[0] == $past(availReg[0]) - $past(cont[0]))
	else $error("quota not reduced by contention");

chk_quota_exhaust: assert property (
	cfgReg.quotaEnable && !cfgReg.quotaReload[1] && !cfgReg.quotaSoftReset
	&& availReg[1] < cont[1] |=> irqQuota[1])
	else $error("exhaustion did not interrupt");

chk_quota_idle: assert property (
	!cfgReg.quotaEnable && !cfgReg.quotaReload[0] && !cfgReg.quotaSoftReset
	|=> $stable(availReg[0]))
	else $error("quota moved while disabled");

chk_dur_sat: assert property (
	cfgReg.durEnable && !cfgReg.durSoftReset && eventIn[7]
	&& durCntReg[7] == `CQDM_CNT_MAX |=> durCntReg[7] == `CQDM_CNT_MAX)
	else $error("pulse counter wrapped");

chk_wmark_keep: assert property (
	!cfgReg.durSoftReset |=> wmarkReg[15:8] >= $past(wmarkReg[15:8]))
	else $error("watermark decreased");

chk_dur_irq: assert property (
	cfgReg.durEnable && !cfgReg.durSoftReset
	&& wmarkReg[7:0] > weightReg[7:0] |=> irqDuration && durVecReg[0])
	else $error("pulse threshold did not interrupt");

chk_ovf_set: assert property (
	counterWrap[1] && ovfMaskReg[1] |=> ovfVecReg[1] && irqOverflow)
	else $error("enabled wrap not flagged");

chk_weight_wr: assert property (
	wrEn && apbReq.paddr == `CQDM_OFS_WEIGHT1 |=> weightReg[63:56] == $past(apbReq.pwdata[31:24]))
	else $error("weight field misplaced");

endmodule

/* File: testbench/cqdm_ev_src.sv */
`timescale 1ns/10ps

module cqdm_ev_src
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// commands
	input  wire logic [7:0]  goMask,
	input  wire logic [8:0]  goLen,
	input  wire logic [23:0] wrapIn,
	// event lines
	output logic [7:0]       eventIn,
	output logic [23:0]      counterWrap,
	output logic             busy
);
	logic [8:0] left_reg;
	logic [7:0] mask_reg;

	// events on crossbar outputs 0..7 held for goLen cycles
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			left_reg    <= 9'h000;
			mask_reg    <= 8'h00;
			counterWrap <= 24'h000000;
		end
		else
		begin
			counterWrap <= wrapIn;
			if (goLen != 9'h000)
			begin
				left_reg <= goLen;
				mask_reg <= goMask;
			end
			else if (left_reg != 9'h000)
				left_reg <= left_reg - 9'h001;
		end
	end
	assign busy    = (left_reg != 9'h000);
	assign eventIn = busy ? mask_reg : 8'h00;
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps

module tb_top;
	logic                    clk;
	logic                    rst_n;
	cqdm_pkg::cqdm_apb_req_s apbReq;
	logic [31:0]             prdata;
	logic                    pready;
	logic                    pslverr;
	logic [7:0]              eventIn;
	logic [23:0]             counterWrap;
	logic                    overflowSoftReset;
	logic [3:0]              irqQuota;
	logic                    irqDuration;
	logic                    irqOverflow;
	logic [7:0]              goMask;
	logic [8:0]              goLen;
	logic [23:0]             wrapIn;
	logic                    busy;
	logic [31:0]             rdData;
	logic                    rdErr;
	int                      nErrors;
	int                      samplesChecked;

	initial clk = 1'b0;
	always #25 clk = ~clk;

	cqdm_top i_cqdm_top (.clk(clk), .rst_n(rst_n), .apbReq(apbReq), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .eventIn(eventIn), .counterWrap(counterWrap),
		.overflowSoftReset(overflowSoftReset), .irqQuota(irqQuota),
		.irqDuration(irqDuration), .irqOverflow(irqOverflow));
	cqdm_ev_src i_cqdm_ev_src (.clk(clk), .rst_n(rst_n), .goMask(goMask), .goLen(goLen),
		.wrapIn(wrapIn), .eventIn(eventIn), .counterWrap(counterWrap), .busy(busy));

	task summarize;
		$display("checks %0d errors %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task fail;
		nErrors++;
		summarize();
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp)
		begin
			nErrors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// setup, access, then hold until pready is sampled high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		apbReq <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk);
		apbReq.penable <= 1'b1;
		for (i = 0; i < 8; i++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 8)
			fail();
		rdData = prdata;
		rdErr = pslverr;
		apbReq <= '0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdData, exp);
	endtask

	task pulse(input logic [7:0] m, input logic [8:0] n);
		int i;
		goMask <= m;
		goLen <= n;
		@(posedge clk);
		goLen <= 9'h000;
		for (i = 0; i < 400; i++)
		begin
			@(posedge clk);
			if (busy === 1'b0)
				break;
		end
		if (i == 400)
			fail();
	endtask

	initial
	begin
		rst_n = 1'b0;
		apbReq = '0;
		goMask = 8'h00;
		goLen = 9'h000;
		wrapIn = 24'h0;
		overflowSoftReset = 1'b0;
		nErrors = 0;
		samplesChecked = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h98, 32'h0);
		rd(8'ha4, 32'h0);
		apb(1'b0, 8'hfc, 32'h0);
		chk({31'h0, rdErr}, 32'h1);
		wr(8'h98, 32'h04030201);
		wr(8'h9c, 32'h08070605);
		rd(8'h98, 32'h04030201);
		rd(8'h9c, 32'h08070605);
		// quota: core0 3, core1 7, core2 11 per cycle
		wr(8'h78, 32'h64);
		wr(8'h7c, 32'ha);
		wr(8'h74, 32'h3c);
		wr(8'h74, 32'h1);
		rd(8'h88, 32'h64);
		pulse(8'h3f, 9'h005);
		rd(8'h88, 32'h55);
		rd(8'h8c, 32'h0);
		chk({28'h0, irqQuota}, 32'h6);
		wr(8'h74, 32'h0);
		pulse(8'h03, 9'h004);
		rd(8'h88, 32'h55);
		wr(8'h88, 32'hff);
		rd(8'h88, 32'h55);
		wr(8'h74, 32'h2);
		wr(8'h74, 32'h0);
		rd(8'h88, 32'h0);
		rd(8'h78, 32'h64);
		chk({28'h0, irqQuota}, 32'h0);
		// duration monitor
		wr(8'h74, 32'h40);
		pulse(8'h80, 9'h12c);
		pulse(8'h01, 9'h003);
		rd(8'ha8, 32'hff000000);
		rd(8'ha4, 32'h3);
		rd(8'ha0, 32'h81);
		chk({31'h0, irqDuration}, 32'h1);
		wr(8'h74, 32'hc0);
		wr(8'h74, 32'h40);
		rd(8'ha4, 32'h0);
		chk({31'h0, irqDuration}, 32'h0);
		rd(8'h98, 32'h04030201);
		pulse(8'h02, 9'h002);
		rd(8'ha4, 32'h200);
		rd(8'ha0, 32'h0);
		// overflow
		wr(8'h64, 32'h2);
		rd(8'h64, 32'h2);
		wrapIn <= 24'h3;
		@(posedge clk);
		wrapIn <= 24'h0;
		rd(8'h68, 32'h2);
		chk({31'h0, irqOverflow}, 32'h1);
		overflowSoftReset <= 1'b1;
		@(posedge clk);
		overflowSoftReset <= 1'b0;
		rd(8'h68, 32'h0);
		chk({31'h0, irqOverflow}, 32'h0);
		summarize();
	end
endmodule
